//--- logic/bcd_decade.sv
// one decade stage of the up/down count register
`timescale 1ns/1ns
module bcd_decade (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic load,
    input wire logic [3:0] load_value,
    input wire logic count_en,
    input wire logic up,
    output logic [3:0] digit,
    output logic terminal
);
    logic [3:0] next_digit;
    wire at_max = digit >= term_pkg::DIGIT_MAX;
    wire at_min = digit == term_pkg::DIGIT_MIN;

    // a loaded non-decimal digit wraps like nine so the count recovers
    assign terminal = up ? at_max : at_min;
    assign next_digit = clear ? term_pkg::DIGIT_MIN :
                        load ? load_value :
                        !count_en ? digit :
                        up ? (at_max ? term_pkg::DIGIT_MIN : digit + 4'h1) :
                        (at_min ? term_pkg::DIGIT_MAX : digit - 4'h1);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            digit <= term_pkg::DIGIT_MIN;
        end else begin
            digit <= next_digit;
        end
    end
endmodule : bcd_decade

//--- logic/term_pkg.sv
// constants for the terminal datapath slice: opcodes, select codes, widths
package term_pkg;
    localparam int COUNT_W = 13;
    localparam int DIGIT_W = 4;
    localparam int WORD_W = 12;
    localparam int BYTE_W = 8;
    localparam int DIGITS = 3;

    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] DIGIT_MIN = 4'h0;

    // count register opcodes
    localparam logic [7:0] OP_CLEAR_COUNT = 8'h61;
    localparam logic [7:0] OP_LOAD_COUNT = 8'h62;
    localparam logic [7:0] OP_INC_COUNT = 8'h64;
    localparam logic [7:0] OP_DEC_COUNT = 8'h68;
    localparam logic [7:0] OP_LOAD_CONST = 8'h9f;

    // distribution group: high nibble, low two bits pick the source
    localparam logic [3:0] OP_DIST_GROUP = 4'hd;
    localparam logic [1:0] DIST_ACC = 2'h0;
    localparam logic [1:0] DIST_INDEX = 2'h1;
    localparam logic [1:0] DIST_JOB = 2'h2;
    localparam logic [1:0] DIST_FIELD = 2'h3;

    // transmit opcodes and select codes (mid, low)
    localparam logic [7:0] OP_XMIT_PAD = 8'he0;
    localparam logic [7:0] OP_XMIT_ACK = 8'he4;
    localparam logic [7:0] OP_XMIT_LOW = 8'he8;
    localparam logic [7:0] OP_XMIT_HIGH = 8'hec;
    localparam logic [1:0] XSEL_PAD = 2'h0;
    localparam logic [1:0] XSEL_ACK = 2'h1;
    localparam logic [1:0] XSEL_DATA_LOW = 2'h2;
    localparam logic [1:0] XSEL_DATA_HIGH = 2'h3;
    localparam logic [7:0] PAD_BYTE = 8'hff;
    localparam logic [7:0] ACK_BYTE = 8'h0e;

    // refresh write selector opcodes
    localparam logic [7:0] OP_RFS_ACC = 8'hf0;
    localparam logic [7:0] OP_RFS_CNT0 = 8'hf1;
    localparam logic [7:0] OP_RFS_CNT1 = 8'hf2;
    localparam logic [7:0] OP_RFS_CNT2 = 8'hf3;
    localparam logic [7:0] OP_RFS_CNT12 = 8'hf4;
    localparam logic [7:0] OP_TEST_BANK = 8'hf8;
    localparam logic [3:0] RFS_HIGH_ONES = 4'hf;
    localparam logic [6:0] RFS_TOP_FILL = 7'h00;

    // panel indicator select {lo, hi}
    localparam logic [1:0] PANEL_INSTR = 2'h0;
    localparam logic [1:0] PANEL_COUNT = 2'h1;
    localparam logic [1:0] PANEL_ACC = 2'h2;
    localparam logic [1:0] PANEL_INDEX = 2'h3;
endpackage : term_pkg

//--- logic/terminal_datapath.sv
// terminal datapath slice: count register and four selectors
// Operation
// - count output is 13 bits, top bit separate
// - each count stage counts decimal decades
// - opcode 62 at T13 loads operand bus
// - branch load command at T14 loads constants
// - opcode 64 at T14 counts up once
// - opcode 68 at T15 counts down once
// - clear on 61@T12, branch clear, init reset
// - panel selector shows instr, count, acc, index
// - distribution routes acc, index, job, field by opcode
// - distribution select latched at T12, held
// - eight-way transmit select, high bit error display
// - select 000 pad byte, 001 acknowledge byte
// - E8/EC send distribution low/high bits
// - pad/ack chosen by opcode or transmit flags
// - selects 100-111 send four error words
// - F0 writes accumulator low byte
// - F1-F3 write count nibbles, high ones
// - F4 writes count top bit, rest zero
// - F8 issues test bit bank select
`timescale 1ns/1ns
module terminal_datapath #(
    parameter int WORD_W = term_pkg::WORD_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] opcode,
    input wire logic slot_t12,
    input wire logic slot_t13,
    input wire logic slot_t14,
    input wire logic slot_t15,
    input wire logic branch_load_count,
    input wire logic branch_clear_count,
    input wire logic init_reset,
    input wire logic [12:0] operand_select_bus,
    input wire logic panel_select_lo,
    input wire logic panel_select_hi,
    input wire logic [3:0] instr_nibble_low,
    input wire logic [3:0] instr_nibble_mid,
    input wire logic [3:0] instr_nibble_high,
    input wire logic [WORD_W-1:0] accumulator_bits,
    input wire logic [WORD_W-1:0] index_reg_bits,
    input wire logic [WORD_W-1:0] job_definition_reg,
    input wire logic [WORD_W-1:0] field_definition_reg,
    input wire logic [11:0] error_reg1,
    input wire logic [11:0] error_reg2,
    input wire logic error_display,
    input wire logic [1:0] error_word_sel,
    input wire logic xmit_flag_pad,
    input wire logic xmit_flag_ack,
    output logic [12:0] count_reg_bits,
    output logic [WORD_W-1:0] panel_indicator,
    output logic [WORD_W-1:0] distribution_out,
    output logic xmit_sel_high,
    output logic xmit_sel_mid,
    output logic xmit_sel_low,
    output logic [7:0] xmit_output_bits,
    output logic [7:0] refresh_write_data,
    output logic refresh_write_valid,
    output logic test_bit_bank_select
);
    localparam int DIGITS = term_pkg::DIGITS;
    localparam int DW = term_pkg::DIGIT_W;

    function automatic logic op_at(input logic [7:0] op,
                                   input logic [7:0] code,
                                   input logic slot);
        op_at = slot && (op == code);
    endfunction : op_at

    // ---------------- count register ----------------
    wire cnt_clear = init_reset
                     || op_at(opcode, term_pkg::OP_CLEAR_COUNT, slot_t12)
                     || (branch_clear_count
                         && op_at(opcode, term_pkg::OP_LOAD_CONST,
                                  slot_t13));
    wire cnt_load_ram = op_at(opcode, term_pkg::OP_LOAD_COUNT,
                              slot_t13);
    wire cnt_load_const = branch_load_count && slot_t14;
    wire cnt_load = cnt_load_ram || cnt_load_const;
    wire cnt_up = op_at(opcode, term_pkg::OP_INC_COUNT, slot_t14);
    wire cnt_down = op_at(opcode, term_pkg::OP_DEC_COUNT,
                          slot_t15);
    wire cnt_step = (cnt_up || cnt_down) && !cnt_load;

    logic [DIGITS-1:0] stage_term;
    logic [DIGITS:0] stage_en;
    logic top_bit;
    logic next_top_bit;
    logic [DW*DIGITS-1:0] digits;

    assign stage_en[0] = cnt_step;

    // each decade steps only when every lower decade wraps
    genvar gi;
    generate
        for (gi = 0; gi < DIGITS; gi++) begin : g_decade
            bcd_decade u_decade (
                .ref_clk(ref_clk),
                .rst(rst),
                .clear(cnt_clear),
                .load(cnt_load),
                .load_value(operand_select_bus[gi*DW +: DW]),
                .count_en(stage_en[gi]),
                .up(cnt_up),
                .digit(digits[gi*DW +: DW]),
                .terminal(stage_term[gi])
            );
            assign stage_en[gi+1] = stage_en[gi] && stage_term[gi];
        end
    endgenerate

    // thirteenth bit behaves as a toggling flip-flop on carry or borrow out of the third decade
    assign next_top_bit = cnt_clear ? 1'b0 :
                          cnt_load ? operand_select_bus[12] :
                          stage_en[DIGITS] ? !top_bit : top_bit;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            top_bit <= 1'b0;
        end else begin
            top_bit <= next_top_bit;
        end
    end

    assign count_reg_bits = {top_bit, digits};

    // ---------------- panel indicator selector ----------------
    wire [1:0] panel_sel = {panel_select_lo, panel_select_hi};
    wire [WORD_W-1:0] instr_word =
        WORD_W'({instr_nibble_high, instr_nibble_mid, instr_nibble_low});
    wire [WORD_W-1:0] count_word = WORD_W'(digits);
    logic [WORD_W-1:0] next_panel;

    always_comb begin
        unique case (panel_sel)
            term_pkg::PANEL_INSTR: next_panel = instr_word;
            term_pkg::PANEL_COUNT: next_panel = count_word;
            term_pkg::PANEL_ACC: next_panel = accumulator_bits;
            term_pkg::PANEL_INDEX: next_panel = index_reg_bits;
        endcase
    end

    // ---------------- distribution selector ----------------
    logic [1:0] dist_sel;
    logic [WORD_W-1:0] next_dist;
    wire dist_take = slot_t12 && (opcode[7:4] == term_pkg::OP_DIST_GROUP);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dist_sel <= term_pkg::DIST_ACC;
        end else if (dist_take) begin
            dist_sel <= opcode[1:0];
        end
    end

    always_comb begin
        unique case (dist_sel)
            term_pkg::DIST_ACC: next_dist = accumulator_bits;
            term_pkg::DIST_INDEX: next_dist = index_reg_bits;
            term_pkg::DIST_JOB: next_dist = job_definition_reg;
            term_pkg::DIST_FIELD: next_dist = field_definition_reg;
        endcase
    end

    // ---------------- transmit selector ----------------
    logic [1:0] xmit_sel;
    logic [1:0] next_xmit_sel;
    logic [7:0] next_xmit;

    // flags from the receive side win over a same-cycle opcode
    always_comb begin
        next_xmit_sel = xmit_sel;
        if (xmit_flag_pad) begin
            next_xmit_sel = term_pkg::XSEL_PAD;
        end else if (xmit_flag_ack) begin
            next_xmit_sel = term_pkg::XSEL_ACK;
        end else if (op_at(opcode, term_pkg::OP_XMIT_PAD, slot_t12)) begin
            next_xmit_sel = term_pkg::XSEL_PAD;
        end else if (op_at(opcode, term_pkg::OP_XMIT_ACK, slot_t12)) begin
            next_xmit_sel = term_pkg::XSEL_ACK;
        end else if (op_at(opcode, term_pkg::OP_XMIT_LOW, slot_t12)) begin
            next_xmit_sel = term_pkg::XSEL_DATA_LOW;
        end else if (op_at(opcode, term_pkg::OP_XMIT_HIGH, slot_t12)) begin
            next_xmit_sel = term_pkg::XSEL_DATA_HIGH;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xmit_sel <= term_pkg::XSEL_PAD;
        end else begin
            xmit_sel <= next_xmit_sel;
        end
    end

    // error display owns the high bit and the word index
    assign xmit_sel_high = error_display;
    wire [1:0] xmit_sel_eff = error_display ? error_word_sel : xmit_sel;
    assign xmit_sel_mid = xmit_sel_eff[1];
    assign xmit_sel_low = xmit_sel_eff[0];

    wire [11:0] m1 = 12'(distribution_out);

    always_comb begin
        unique case ({xmit_sel_high, xmit_sel_eff})
            3'h0: next_xmit = term_pkg::PAD_BYTE;
            3'h1: next_xmit = term_pkg::ACK_BYTE;
            3'h2: next_xmit = m1[7:0];
            3'h3: next_xmit = {4'h0, m1[11:8]};
            // bit 0 of each byte is the first transmitted line
            3'h4: next_xmit = {2'b00, error_reg1[6], error_reg1[7],
                               error_reg1[8], error_reg1[9],
                               error_reg1[10], 1'b0};
            3'h5: next_xmit = {2'b01, error_reg1[5:0]};
            3'h6: next_xmit = {2'b10, error_reg2[11:6]};
            3'h7: next_xmit = {2'b11, error_reg2[5:0]};
        endcase
    end

    // ---------------- refresh write selector ----------------
    wire rfs_acc = op_at(opcode, term_pkg::OP_RFS_ACC, slot_t12);
    wire rfs_c0 = op_at(opcode, term_pkg::OP_RFS_CNT0, slot_t12);
    wire rfs_c1 = op_at(opcode, term_pkg::OP_RFS_CNT1, slot_t12);
    wire rfs_c2 = op_at(opcode, term_pkg::OP_RFS_CNT2, slot_t12);
    wire rfs_c12 = op_at(opcode, term_pkg::OP_RFS_CNT12, slot_t12);
    wire rfs_any = rfs_acc || rfs_c0 || rfs_c1 || rfs_c2 || rfs_c12;
    wire test_bank = op_at(opcode, term_pkg::OP_TEST_BANK,
                           slot_t12);
    logic [7:0] next_rfs;

    always_comb begin
        next_rfs = refresh_write_data;
        if (rfs_acc) begin
            next_rfs = accumulator_bits[7:0];
        end else if (rfs_c0) begin
            next_rfs = {term_pkg::RFS_HIGH_ONES,
                        count_reg_bits[3:0]};
        end else if (rfs_c1) begin
            next_rfs = {term_pkg::RFS_HIGH_ONES, count_reg_bits[7:4]};
        end else if (rfs_c2) begin
            next_rfs = {term_pkg::RFS_HIGH_ONES, count_reg_bits[11:8]};
        end else if (rfs_c12) begin
            next_rfs = {term_pkg::RFS_TOP_FILL,
                        count_reg_bits[12]};
        end
    end

    // ---------------- output registers ----------------
    // one cycle of latency keeps every data output glitch free
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            panel_indicator <= '0;
            distribution_out <= '0;
            xmit_output_bits <= '0;
            refresh_write_data <= '0;
            refresh_write_valid <= 1'b0;
            test_bit_bank_select <= 1'b0;
        end else begin
            panel_indicator <= next_panel;
            distribution_out <= next_dist;
            xmit_output_bits <= next_xmit;
            refresh_write_data <= next_rfs;
            refresh_write_valid <= rfs_any;
            test_bit_bank_select <= test_bank;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_INIT_CLEAR: assert property (init_reset |=> count_reg_bits == 13'h0)
        else $error("init reset did not clear count");
    AST_OP_CLEAR: assert property (
        op_at(opcode, term_pkg::OP_CLEAR_COUNT, slot_t12) |=>
        count_reg_bits == 13'h0)
        else $error("clear opcode did not clear count");
    AST_LOAD_RAM: assert property (cnt_load_ram && !cnt_clear |=>
        count_reg_bits == $past(operand_select_bus))
        else $error("ram load mismatch");
    AST_LOAD_CONST: assert property (cnt_load_const && !cnt_clear |=>
        count_reg_bits == $past(operand_select_bus))
        else $error("constant load mismatch");
    AST_COUNT_UP: assert property (cnt_up && !cnt_clear && !cnt_load
        && count_reg_bits[3:0] < 4'h9 |=>
        count_reg_bits[3:0] == $past(count_reg_bits[3:0]) + 4'h1)
        else $error("count up failed");
    AST_DECADE_WRAP: assert property (cnt_up && !cnt_clear && !cnt_load
        && count_reg_bits[7:0] == 8'h09 |=> count_reg_bits[7:0] == 8'h10)
        else $error("decade carry failed");
    AST_COUNT_DOWN: assert property (cnt_down && !cnt_clear && !cnt_load
        && count_reg_bits[3:0] != 4'h0 && count_reg_bits[3:0] <= 4'h9 |=>
        count_reg_bits[3:0] == $past(count_reg_bits[3:0]) - 4'h1)
        else $error("count down failed");
    AST_PANEL_COUNT: assert property (panel_sel == term_pkg::PANEL_COUNT
        |=> panel_indicator == $past(count_word))
        else $error("panel count view wrong");
    AST_DIST_INDEX: assert property (
        op_at(opcode, 8'hd1, slot_t12) ##1 !dist_take |=>
        distribution_out == $past(index_reg_bits))
        else $error("distribution index route wrong");
    AST_XMIT_PAD: assert property (
        !error_display && op_at(opcode, term_pkg::OP_XMIT_PAD, slot_t12)
        && !xmit_flag_ack ##1 !error_display && !xmit_flag_ack
        && !(slot_t12 && opcode[7:4] == 4'he) |=>
        xmit_output_bits == term_pkg::PAD_BYTE)
        else $error("pad byte not sent");
    AST_ERR_WORD: assert property (error_display && error_word_sel == 2'h3
        |=> xmit_output_bits == {2'b11, $past(error_reg2[5:0])})
        else $error("error word 3 wrong");
    AST_RFS_NIBBLE: assert property (rfs_c0 |=> refresh_write_valid
        && refresh_write_data == {4'hf, $past(count_reg_bits[3:0])})
        else $error("refresh nibble wrong");
    AST_TEST_BANK: assert property (test_bank |=> test_bit_bank_select)
        else $error("test bank select missing");
    AST_DIST_JOB: assert property (
        op_at(opcode, 8'hd2, slot_t12) ##1 !dist_take |=>
        distribution_out == $past(job_definition_reg))
        else $error("distribution job route wrong");
    AST_XMIT_LOW: assert property (
        op_at(opcode, term_pkg::OP_XMIT_LOW, slot_t12) && !xmit_flag_pad
        && !xmit_flag_ack ##1 !error_display |=>
        xmit_output_bits == $past(distribution_out[7:0]))
        else $error("transmit low data wrong");
    // a flag only moves the select; the byte follows one edge later
    AST_ACK_FLAG: assert property (
        xmit_flag_ack && !xmit_flag_pad ##1 !error_display |=>
        xmit_output_bits == 8'h0e)
        else $error("ack flag byte not sent");
    AST_RFS_ACC: assert property (
        rfs_acc |=> refresh_write_valid
        && refresh_write_data == $past(accumulator_bits[7:0]))
        else $error("refresh accumulator byte wrong");
    AST_RFS_TOP: assert property (
        rfs_c12 |=>
        refresh_write_data == {7'h00, $past(count_reg_bits[12])})
        else $error("refresh top bit wrong");

    COV_WRAP: cover property (cnt_up && stage_en[DIGITS]);
    COV_BORROW: cover property (cnt_down && count_reg_bits == 13'h0);
    COV_ERR: cover property (error_display ##1 !error_display);
    COV_ACK_FLAG: cover property (xmit_flag_pad ##1 xmit_flag_ack);
    COV_LOAD_CONST: cover property (cnt_load_const);
endmodule : terminal_datapath

//--- testbench/instr_decoder_model.sv
// partner model: instruction decoder, branch control and transmit flags
`timescale 1ns/1ns
module instr_decoder_model (
    input wire logic ref_clk,
    output logic [7:0] opcode,
    output logic slot_t12,
    output logic slot_t13,
    output logic slot_t14,
    output logic slot_t15,
    output logic branch_load_count,
    output logic branch_clear_count,
    output logic xmit_flag_pad,
    output logic xmit_flag_ack
);
    initial begin
        opcode = 8'h00;
        {slot_t12, slot_t13, slot_t14, slot_t15} = 4'h0;
        {branch_load_count, branch_clear_count} = 2'h0;
        {xmit_flag_pad, xmit_flag_ack} = 2'h0;
    end

    // kind 1 is a branch load, kind 2 a branch clear
    task automatic issue(input logic [7:0] op, input int slot, input int kind);
        @(posedge ref_clk);
        #10;
        opcode = op;
        slot_t12 = (slot == 12);
        slot_t13 = (slot == 13);
        slot_t14 = (slot == 14);
        slot_t15 = (slot == 15);
        branch_load_count = (kind == 1);
        branch_clear_count = (kind == 2);
        @(posedge ref_clk);
        #10;
        {slot_t12, slot_t13, slot_t14, slot_t15} = 4'h0;
        {branch_load_count, branch_clear_count} = 2'h0;
        // a released opcode never keeps its last value, so decode must
        // lean on the slot strobes alone
        opcode = ~op;
    endtask : issue

    task automatic raise_flag(input logic pad);
        @(posedge ref_clk);
        #10;
        xmit_flag_pad = pad;
        xmit_flag_ack = !pad;
        @(posedge ref_clk);
        #10;
        {xmit_flag_pad, xmit_flag_ack} = 2'h0;
    endtask : raise_flag
endmodule : instr_decoder_model

//--- testbench/terminal_datapath_test.sv
// self-checking bench for the terminal datapath slice
`timescale 1ns/1ns
module terminal_datapath_test;
    logic ref_clk, rst, init_reset, panel_select_lo, panel_select_hi;
    logic error_display, xmit_flag_pad, xmit_flag_ack;
    logic slot_t12, slot_t13, slot_t14, slot_t15;
    logic branch_load_count, branch_clear_count;
    logic xmit_sel_high, xmit_sel_mid, xmit_sel_low;
    logic refresh_write_valid, test_bit_bank_select;
    logic [7:0] opcode, xmit_output_bits, refresh_write_data;
    logic [12:0] operand_select_bus, count_reg_bits;
    logic [3:0] instr_nibble_low, instr_nibble_mid, instr_nibble_high;
    logic [11:0] accumulator_bits, index_reg_bits, job_definition_reg;
    logic [11:0] field_definition_reg, error_reg1, error_reg2;
    logic [11:0] panel_indicator, distribution_out;
    logic [1:0] error_word_sel;
    int failures = 0;
    int comparisons = 0;

    instr_decoder_model instr_decoder_model_inst (.ref_clk(ref_clk),
        .opcode(opcode), .slot_t12(slot_t12), .slot_t13(slot_t13),
        .slot_t14(slot_t14), .slot_t15(slot_t15),
        .branch_load_count(branch_load_count),
        .branch_clear_count(branch_clear_count),
        .xmit_flag_pad(xmit_flag_pad), .xmit_flag_ack(xmit_flag_ack));

    terminal_datapath terminal_datapath_inst (.ref_clk(ref_clk), .rst(rst),
        .opcode(opcode), .slot_t12(slot_t12), .slot_t13(slot_t13),
        .slot_t14(slot_t14), .slot_t15(slot_t15),
        .branch_load_count(branch_load_count),
        .branch_clear_count(branch_clear_count), .init_reset(init_reset),
        .operand_select_bus(operand_select_bus),
        .panel_select_lo(panel_select_lo), .panel_select_hi(panel_select_hi),
        .instr_nibble_low(instr_nibble_low),
        .instr_nibble_mid(instr_nibble_mid),
        .instr_nibble_high(instr_nibble_high),
        .accumulator_bits(accumulator_bits), .index_reg_bits(index_reg_bits),
        .job_definition_reg(job_definition_reg),
        .field_definition_reg(field_definition_reg),
        .error_reg1(error_reg1), .error_reg2(error_reg2),
        .error_display(error_display), .error_word_sel(error_word_sel),
        .xmit_flag_pad(xmit_flag_pad), .xmit_flag_ack(xmit_flag_ack),
        .count_reg_bits(count_reg_bits), .panel_indicator(panel_indicator),
        .distribution_out(distribution_out), .xmit_sel_high(xmit_sel_high),
        .xmit_sel_mid(xmit_sel_mid), .xmit_sel_low(xmit_sel_low),
        .xmit_output_bits(xmit_output_bits),
        .refresh_write_data(refresh_write_data),
        .refresh_write_valid(refresh_write_valid),
        .test_bit_bank_select(test_bit_bank_select));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic step();
        @(posedge ref_clk);
        #10;
    endtask : step

    task automatic op(input logic [7:0] code, input int slot, input int k);
        instr_decoder_model_inst.issue(code, slot, k);
    endtask : op

    task automatic t_count();
        operand_select_bus = 13'h0998;
        op(8'h62, 13, 0);
        check("count load", 16'(count_reg_bits), 16'h0998);
        op(8'h64, 14, 0);
        check("count up", 16'(count_reg_bits), 16'h0999);
        op(8'h64, 14, 0);
        check("count carry", 16'(count_reg_bits), 16'h1000);
        op(8'h68, 15, 0);
        check("count down", 16'(count_reg_bits), 16'h0999);
        op(8'h64, 13, 0);
        check("count wrong slot", 16'(count_reg_bits), 16'h0999);
        op(8'h61, 12, 0);
        check("count clear", 16'(count_reg_bits), 16'h0000);
        op(8'h68, 15, 0);
        check("count borrow", 16'(count_reg_bits), 16'h1999);
        operand_select_bus = 13'h0123;
        op(8'h00, 14, 1);
        check("branch load", 16'(count_reg_bits), 16'h0123);
        op(8'h9f, 13, 2);
        check("branch clear", 16'(count_reg_bits), 16'h0000);
        operand_select_bus = 13'h1987;
        op(8'h62, 13, 0);
        init_reset = 1'b1;
        step();
        init_reset = 1'b0;
        check("init clear", 16'(count_reg_bits), 16'h0000);
        op(8'h62, 13, 0);
        $display("count test done");
    endtask : t_count

    task automatic t_panel();
        logic [11:0] exp [4];
        exp = '{{instr_nibble_high, instr_nibble_mid, instr_nibble_low},
                12'h987, accumulator_bits, index_reg_bits};
        for (int c = 0; c < 4; c++) begin
            {panel_select_lo, panel_select_hi} = 2'(c);
            step();
            step();
            check("panel", 16'(panel_indicator), 16'(exp[c]));
        end
        $display("panel test done");
    endtask : t_panel

    task automatic t_dist();
        logic [11:0] src [4];
        src = '{accumulator_bits, index_reg_bits, job_definition_reg,
                field_definition_reg};
        for (int x = 3; x >= 0; x--) begin
            op({6'h34, 2'(x)}, 12, 0);
            step();
            check("dist", 16'(distribution_out),
                  16'(src[x]));
        end
        op(8'hd3, 13, 0);
        step();
        check("dist hold", 16'(distribution_out), 16'(src[0]));
        $display("distribution test done");
    endtask : t_dist

    task automatic t_xmit();
        logic [7:0] xop [4];
        logic [7:0] xexp [4];
        logic [7:0] eexp [4];
        xop = '{8'he0, 8'he4, 8'he8, 8'hec};
        xexp = '{8'hff, 8'h0e, accumulator_bits[7:0],
                 {4'h0, accumulator_bits[11:8]}};
        eexp = '{{2'b00, error_reg1[6], error_reg1[7], error_reg1[8],
                  error_reg1[9], error_reg1[10], 1'b0},
                 {2'b01, error_reg1[5:0]}, {2'b10, error_reg2[11:6]},
                 {2'b11, error_reg2[5:0]}};
        for (int i = 0; i < 4; i++) begin
            op(xop[i], 12, 0);
            check("xmit sel",
                  16'({xmit_sel_high, xmit_sel_mid, xmit_sel_low}),
                  16'(i));
            step();
            check("xmit data", 16'(xmit_output_bits),
                  16'(xexp[i]));
        end
        instr_decoder_model_inst.raise_flag(1'b0);
        step();
        check("ack flag", 16'(xmit_output_bits), 16'h000e);
        instr_decoder_model_inst.raise_flag(1'b1);
        step();
        check("pad flag", 16'(xmit_output_bits), 16'h00ff);
        error_display = 1'b1;
        for (int w = 0; w < 4; w++) begin
            error_word_sel = 2'(w);
            step();
            step();
            check("err high", 16'(xmit_sel_high), 16'h0001);
            check("err word", 16'(xmit_output_bits),
                  16'(eexp[w]));
        end
        error_display = 1'b0;
        #1;
        check("err off", 16'(xmit_sel_high), 16'h0000);
        $display("transmit test done");
    endtask : t_xmit

    task automatic t_refresh();
        logic [7:0] rexp [5];
        rexp = '{accumulator_bits[7:0], 8'hf7, 8'hf8, 8'hf9, 8'h01};
        for (int i = 0; i < 5; i++) begin
            op(8'hf0 + 8'(i), 12, 0);
            check("rfs valid", 16'(refresh_write_valid),
                  16'h0001);
            check("rfs data", 16'(refresh_write_data),
                  16'(rexp[i]));
        end
        op(8'hf8, 12, 0);
        check("bank sel", 16'(test_bit_bank_select),
              16'h0001);
        check("rfs hold", 16'(refresh_write_data),
              16'h0001);
        step();
        check("bank pulse", 16'(test_bit_bank_select),
              16'h0000);
        check("valid pulse", 16'(refresh_write_valid),
              16'h0000);
        $display("refresh test done");
    endtask : t_refresh

    initial begin
        // one cycle per step, so this span is ample for every task
        #2_000_000;
        failures++;
        conclude();
    end

    initial begin
        {rst, init_reset, error_display} = 3'h4;
        {panel_select_lo, panel_select_hi} = 2'h0;
        operand_select_bus = 13'h0000;
        {instr_nibble_high, instr_nibble_mid, instr_nibble_low} = 12'hc63;
        accumulator_bits = 12'h5a7;
        index_reg_bits = 12'h2b4;
        job_definition_reg = 12'h71e;
        field_definition_reg = 12'he83;
        error_reg1 = 12'h6c5;
        error_reg2 = 12'h3a9;
        error_word_sel = 2'h0;
        repeat (12) @(posedge ref_clk);
        #10;
        rst = 1'b0;
        check("reset count", 16'(count_reg_bits), 16'h0000);
        step();
        check("reset xmit", 16'(xmit_output_bits), 16'h00ff);
        t_count();
        t_panel();
        t_dist();
        t_xmit();
        t_refresh();
        conclude();
    end
endmodule : terminal_datapath_test
